/* File: design/aac_pkg.sv */
// constants, field layout and types shared by the acquisition control files
package aac_pkg;
    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int AAC_NUM_DEV      = 2;
    localparam int AAC_NUM_CH       = 8;
    localparam int AAC_DW           = 16;
    localparam int AAC_AW           = 8;
    localparam int AAC_RANGE_W      = 3;
    localparam int AAC_CNT_W        = 4;
    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] AAC_CTRL_OFS  = 8'h00;
    localparam logic [7:0] AAC_STAT_OFS  = 8'h04;
    localparam logic [7:0] AAC_MODE_OFS  = 8'h08;
    localparam logic [7:0] AAC_CFG_OFS   = 8'h10;
    localparam logic [7:0] AAC_CORR_OFS  = 8'h40;
    localparam logic [7:0] AAC_RANGE_OFS = 8'h80;
    localparam logic [7:0] AAC_DATA_OFS  = 8'hc0;
    localparam logic [7:0] AAC_REGION_M  = 8'hc0;
    // ------------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------------
    localparam int AAC_MODE_SEQ_BIT = 0;
    localparam int AAC_CFG_DIFF_BIT = 0;
    localparam int AAC_CFG_CNT_LSB  = 4;
    localparam int AAC_CORR_OFF_LSB = 16;
    localparam int AAC_STAT_ACT_BIT = 8;
    localparam logic [AAC_CNT_W-1:0]   AAC_CNT_RST   = 4'h1;
    localparam logic [AAC_CNT_W-1:0]   AAC_MAX_DIFF  = 4'h4;
    localparam logic [AAC_CNT_W-1:0]   AAC_MAX_SE    = 4'h8;
    localparam logic [AAC_RANGE_W-1:0] AAC_RANGE_RST = 3'h0;
    // range codes: 0.166, 0.2, 0.4, 0.8, 1.6
    localparam logic [AAC_RANGE_W-1:0] AAC_RANGE_G1P6 = 3'h4;
    // ------------------------------------------------------------------
    // correction scaling: gain / 262144, offset / 4
    // ------------------------------------------------------------------
    localparam int AAC_GAIN_DIV     = 262144;
    localparam int AAC_GAIN_SHIFT   = 18;
    localparam int AAC_OFF_SHIFT    = 16;
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        AAC_IDLE,
        AAC_START,
        AAC_WAIT,
        AAC_STORE
    } aac_state_t;
endpackage

/* File: design/aac_corr.sv */
// gain and offset correction of one raw conversion result
`timescale 1ns/1ps
module aac_corr
    import aac_pkg::*;
(
    // raw result and correction values
    input  wire logic signed [AAC_DW-1:0] raw,
    input  wire logic signed [AAC_DW-1:0] gain_corr,
    input  wire logic signed [AAC_DW-1:0] off_corr,
    // corrected result
    output logic signed [AAC_DW-1:0]      result
);
    // ------------------------------------------------------------------
    // arithmetic
    // ------------------------------------------------------------------
    // gain factor scaled by 2^18, offset by 2^16, so zero corrections give raw back exactly
    logic signed [19:0] factor;
    logic signed [36:0] acc;
    logic signed [18:0] scaled;

    always_comb
    begin
        factor = 20'(AAC_GAIN_DIV) - 20'(gain_corr);
        // widen before multiplying so the product cannot overflow
        acc    = 37'(raw) * 37'(factor)
               - (37'(off_corr) <<< AAC_OFF_SHIFT);
        scaled = 19'(acc >>> AAC_GAIN_SHIFT);
        // saturate rather than wrap past full scale
        if (scaled > 19'sd32767)
            result = 16'sh7fff;
        else if (scaled < -19'sd32768)
            result = 16'sh8000;
        else
            result = scaled[AAC_DW-1:0];
    end
endmodule // aac_corr

/* File: design/aac_adc_ctrl.sv */
// converter acquisition control with avalon register slave
`timescale 1ns/1ps
module aac_adc_ctrl
    import aac_pkg::*;
#(
    parameter int NUM_DEV = AAC_NUM_DEV
)
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    // avalon-mm slave
    input  wire logic [aac_pkg::AAC_AW-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    output logic [31:0]                     avs_readdata,
    output logic                            avs_waitrequest,
    // board straps and sequencer clock (asynchronous pins)
    input  wire logic [NUM_DEV-1:0]         current_input,
    input  wire logic                       seq_clk_event,
    // converter devices
    output logic                            conv_start,
    output logic [2:0]                      conv_channel,
    output logic [NUM_DEV-1:0]              conv_enable,
    output logic [NUM_DEV-1:0]              conv_diff,
    output logic [NUM_DEV*3-1:0]            conv_range,
    input  wire logic                       conv_done,
    input  wire logic [NUM_DEV*16-1:0]      conv_data,
    // host memory writes in sequencer mode
    output logic [NUM_DEV-1:0]              host_wr_valid,
    output logic [2:0]                      host_wr_ch,
    output logic [NUM_DEV*16-1:0]           host_wr_data
);
    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    localparam int NE = NUM_DEV * AAC_NUM_CH;
    localparam int EW = $clog2(NE);

    aac_state_t                  state;
    logic [NUM_DEV-1:0]          seq_mode, diff_mode, busy, pend_man;
    logic [NUM_DEV-1:0]          run_dev, slot_act, new_req;
    logic                        pend_seq, run_seq, ack, fin;
    logic                        take_man, take_seq;
    logic [3:0]                  ch_idx;
    logic [AAC_CNT_W-1:0]        act_cnt [NUM_DEV];
    logic [AAC_CNT_W-1:0]        eff_cnt [NUM_DEV];
    logic signed [AAC_DW-1:0]    gain_corr [NE];
    logic signed [AAC_DW-1:0]    off_corr [NE];
    logic [AAC_RANGE_W-1:0]      range_sel [NE];
    logic [AAC_DW-1:0]           data_reg [NE];
    logic signed [AAC_DW-1:0]    raw [NUM_DEV];
    logic signed [AAC_DW-1:0]    corr [NUM_DEV];
    logic [NUM_DEV-1:0]          cur_s1, cur_s2;
    logic                        seq_s1, seq_s2, seq_s3;
    logic                        done_s1, done_s2, done_s3;
    logic [NUM_DEV*16-1:0]       dat_s1, dat_s2;
    logic [31:0]                 rd_val;
    logic                        wr_en, wr_ctrl, seq_evt, done_evt;
    logic [EW-1:0]               a_ent;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cur_s1  <= '0;
            cur_s2  <= '0;
            seq_s1  <= 1'b0;
            seq_s2  <= 1'b0;
            seq_s3  <= 1'b0;
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_s3 <= 1'b0;
            dat_s1  <= '0;
            dat_s2  <= '0;
        end
        else
        begin
            cur_s1  <= current_input;
            cur_s2  <= cur_s1;
            seq_s1  <= seq_clk_event;
            seq_s2  <= seq_s1;
            seq_s3  <= seq_s2;
            done_s1 <= conv_done;
            done_s2 <= done_s1;
            done_s3 <= done_s2;
            // data settle before done, so equal latency keeps them paired
            dat_s1  <= conv_data;
            dat_s2  <= dat_s1;
        end
    end

    assign seq_evt  = seq_s2 & ~seq_s3;
    assign done_evt = done_s2 & ~done_s3;

    // ------------------------------------------------------------------
    // avalon slave: one wait cycle, answer on the second edge
    // ------------------------------------------------------------------
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_en   = avs_write & ack;
    assign a_ent   = avs_address[EW+1:2];
    assign wr_ctrl = wr_en && avs_address == AAC_CTRL_OFS;
    // requests to sequencer-mode devices are ignored
    assign new_req = wr_ctrl ? avs_writedata[NUM_DEV-1:0] & ~seq_mode
                             : '0;

    // limitation: the mode window holds at most two devices, the config window up to twelve
    always_comb
    begin
        rd_val = 32'h0;
        unique case (avs_address & AAC_REGION_M)
            AAC_CORR_OFS:
                rd_val = {off_corr[a_ent], gain_corr[a_ent]};
            AAC_RANGE_OFS:
                rd_val = 32'(range_sel[a_ent]);
            AAC_DATA_OFS:
                rd_val = 32'(data_reg[a_ent]);
            default:
                for (int d = 0; d < NUM_DEV; d++)
                begin
                    if (avs_address == AAC_STAT_OFS)
                        rd_val = 32'(busy)
                               | (32'(state != AAC_IDLE) << AAC_STAT_ACT_BIT);
                    if (avs_address == AAC_MODE_OFS + 8'(4 * d))
                        rd_val = 32'(seq_mode[d]);
                    if (avs_address == AAC_CFG_OFS + 8'(4 * d))
                        rd_val = 32'(diff_mode[d])
                               | (32'(eff_cnt[d]) << AAC_CFG_CNT_LSB);
                end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0;
        end
        else
        begin
            ack          <= (avs_read | avs_write) & ~ack;
            avs_readdata <= rd_val;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            seq_mode  <= '0;
            diff_mode <= '0;
            for (int d = 0; d < NUM_DEV; d++)
                act_cnt[d] <= AAC_CNT_RST;
            for (int e = 0; e < NE; e++)
            begin
                gain_corr[e] <= '0;
                off_corr[e]  <= '0;
                range_sel[e] <= AAC_RANGE_RST;
            end
        end
        else if (wr_en)
        begin
            for (int d = 0; d < NUM_DEV; d++)
            begin
                if (avs_address == AAC_MODE_OFS + 8'(4 * d))
                    seq_mode[d] <= avs_writedata[AAC_MODE_SEQ_BIT];
                if (avs_address == AAC_CFG_OFS + 8'(4 * d))
                begin
                    diff_mode[d] <= avs_writedata[AAC_CFG_DIFF_BIT];
                    act_cnt[d]   <= avs_writedata[AAC_CFG_CNT_LSB +: 4];
                end
            end
            if ((avs_address & AAC_REGION_M) == AAC_CORR_OFS)
            begin
                // software supplies the factory values for mode and range
                gain_corr[a_ent] <= avs_writedata[15:0];
                off_corr[a_ent]  <= avs_writedata[AAC_CORR_OFF_LSB +: 16];
            end
            if ((avs_address & AAC_REGION_M) == AAC_RANGE_OFS)
                range_sel[a_ent] <= avs_writedata[AAC_RANGE_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // active slots and correction
    // ------------------------------------------------------------------
    always_comb
    begin
        for (int d = 0; d < NUM_DEV; d++)
        begin
            // over-range counts are capped, not trusted
            eff_cnt[d] = act_cnt[d];
            if (diff_mode[d] && act_cnt[d] > AAC_MAX_DIFF)
                eff_cnt[d] = AAC_MAX_DIFF;
            else if (act_cnt[d] > AAC_MAX_SE)
                eff_cnt[d] = AAC_MAX_SE;
            slot_act[d] = run_dev[d] && ch_idx < 4'(eff_cnt[d]);
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_DEV; g++)
        begin : g_corr
            aac_corr u_corr (
                .raw       (raw[g]),
                .gain_corr (gain_corr[EW'(g * AAC_NUM_CH) + EW'(ch_idx)]),
                .off_corr  (off_corr[EW'(g * AAC_NUM_CH) + EW'(ch_idx)]),
                .result    (corr[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // request bookkeeping and busy
    // ------------------------------------------------------------------
    assign take_man = state == AAC_IDLE && |pend_man;
    assign take_seq = state == AAC_IDLE && !(|pend_man) && pend_seq
                      && |seq_mode;
    assign fin      = state == AAC_START && !(|slot_act);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pend_man <= '0;
            pend_seq <= 1'b0;
            busy     <= '0;
        end
        else
        begin
            // a request in the clearing cycle survives
            pend_man <= (take_man ? '0 : pend_man) | new_req;
            pend_seq <= ((state == AAC_IDLE && !(|pend_man)) ? 1'b0
                         : pend_seq) | seq_evt;
            // a queued rerun keeps its device busy
            busy     <= (fin && !run_seq ? busy & ~(run_dev & ~pend_man)
                         : busy)
                        | new_req;
        end
    end

    // ------------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state         <= AAC_IDLE;
            run_dev       <= '0;
            run_seq       <= 1'b0;
            ch_idx        <= 4'h0;
            conv_start    <= 1'b0;
            conv_channel  <= 3'h0;
            conv_enable   <= '0;
            conv_range    <= '0;
            host_wr_valid <= '0;
            host_wr_ch    <= 3'h0;
            host_wr_data  <= '0;
            for (int d = 0; d < NUM_DEV; d++)
                raw[d] <= '0;
        end
        else
        begin
            conv_start    <= 1'b0;
            host_wr_valid <= '0;
            unique case (state)
                AAC_IDLE:
                    if (take_man || take_seq)
                    begin
                        run_dev <= take_man ? pend_man : seq_mode;
                        run_seq <= !take_man;
                        ch_idx  <= 4'h0;
                        state   <= AAC_START;
                    end
                AAC_START:
                    if (fin)
                        state <= AAC_IDLE;
                    else
                    begin
                        // one slot for every device keeps them in step
                        conv_start   <= 1'b1;
                        conv_channel <= ch_idx[2:0];
                        conv_enable  <= slot_act;
                        for (int d = 0; d < NUM_DEV; d++)
                            conv_range[d*3 +: 3] <= cur_s2[d]
                                ? AAC_RANGE_G1P6
                                : range_sel[EW'(d * AAC_NUM_CH)
                                            + EW'(ch_idx)];
                        state <= AAC_WAIT;
                    end
                AAC_WAIT:
                    if (done_evt)
                    begin
                        for (int d = 0; d < NUM_DEV; d++)
                            raw[d] <= dat_s2[d*16 +: 16];
                        state <= AAC_STORE;
                    end
                AAC_STORE:
                begin
                    if (run_seq)
                    begin
                        host_wr_valid <= slot_act;
                        host_wr_ch    <= ch_idx[2:0];
                        for (int d = 0; d < NUM_DEV; d++)
                            host_wr_data[d*16 +: 16] <= corr[d];
                    end
                    ch_idx <= ch_idx + 4'h1;
                    state  <= AAC_START;
                end
            endcase
        end
    end

    assign conv_diff = diff_mode;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            for (int e = 0; e < NE; e++)
                data_reg[e] <= '0;
        else if (state == AAC_STORE && !run_seq)
            for (int d = 0; d < NUM_DEV; d++)
                if (slot_act[d])
                    data_reg[EW'(d * AAC_NUM_CH) + EW'(ch_idx)]
                        <= corr[d];
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    slot_enable_a: assert property (conv_start |-> conv_enable == slot_act
        && conv_channel == ch_idx[2:0])
        else $error("converter enables differ from active slots");
    chan_step_a: assert property (state == AAC_STORE |=> state == AAC_START
        && ch_idx == $past(ch_idx) + 4'h1)
        else $error("channel index did not step by one");
    chan_zero_a: assert property ((take_man || take_seq) |=> ch_idx == 4'h0
        && state == AAC_START)
        else $error("sequence did not begin at channel 0");
    cnt_cap_a: assert property (diff_mode[0] |-> eff_cnt[0] <= AAC_MAX_DIFF
        && eff_cnt[0] <= act_cnt[0])
        else $error("differential count above four");
    busy_set_a: assert property (|new_req |=> (busy & $past(new_req))
        == $past(new_req))
        else $error("busy not set after manual request");
    busy_hold_a: assert property ((!fin && |busy) |=>
        (busy & $past(busy)) == $past(busy))
        else $error("busy cleared before last result stored");
    seq_take_a: assert property (take_seq |=> run_seq && run_dev
        == $past(seq_mode))
        else $error("sequencer event did not take sequencer devices");
    manual_gate_a: assert property ((state == AAC_IDLE ##1
        (state == AAC_START && !run_seq)) |-> $past(|pend_man))
        else $error("manual run without request");
    host_write_a: assert property ((state == AAC_STORE && run_seq) |=>
        host_wr_valid == $past(slot_act)
        && host_wr_data[15:0] == $past(corr[0]))
        else $error("host write missing after sequencer result");
    pass_raw_a: assert property ((state == AAC_STORE && gain_corr[EW'(ch_idx)]
        == 16'sh0 && off_corr[EW'(ch_idx)] == 16'sh0) |-> corr[0] == raw[0])
        else $error("zero correction altered the result");
    clamp_top_a: assert property ((state == AAC_STORE && raw[0] == 16'sh7fff
        && gain_corr[EW'(ch_idx)] == 16'sh0 && off_corr[EW'(ch_idx)][15])
        |-> corr[0] == 16'sh7fff)
        else $error("corrected result wrapped past full scale");
    range_cur_a: assert property ((conv_start && $past(cur_s2[0]))
        |-> conv_range[2:0] == AAC_RANGE_G1P6)
        else $error("current input device not at gain 1.6");

    manual_done_c: cover property (fin && !run_seq && |run_dev);
    seq_host_c: cover property (|host_wr_valid);
    back_to_back_c: cover property (fin ##[1:4] conv_start);
endmodule // aac_adc_ctrl

/* File: dv/aac_adc_model.sv */
// behavioural converter pair answering each conversion slot
`timescale 1ns/1ps
module aac_adc_model
(
    // clock, slot control and base raw value
    input  wire logic        clk,
    input  wire logic        conv_start,
    input  wire logic [2:0]  conv_channel,
    input  wire logic [15:0] raw0,
    // results
    output logic             conv_done,
    output logic [31:0]      conv_data
);
    logic [2:0]       dly = 3'h0;
    logic [2:0]       ch  = 3'h0;
    wire logic [15:0] base = raw0 + {5'h0, ch, 8'h00};
    initial conv_done = 1'b0;
    initial conv_data = 32'h0;
    // old word turns invalid at each start, so a stale result cannot pass
    always @(posedge clk)
    begin
        dly <= (dly != 3'h0) ? dly - 3'h1 : 3'h0;
        if (dly == 3'h2) conv_data <= {base + 16'h0010, base};
        if (dly == 3'h1) conv_done <= 1'b1;
        if (conv_start)
        begin
            conv_done <= 1'b0;
            conv_data <= ~conv_data;
            ch        <= conv_channel;
            dly       <= 3'h4;
        end
    end
endmodule // aac_adc_model

/* File: dv/tb_adc_acquisition_control.sv */
// self-checking bench for the acquisition control block
`timescale 1ns/1ps
module tb_adc_acquisition_control;
    import aac_pkg::*;
    logic clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, seq_ev = 0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q, conv_data, hd;
    logic avs_waitrequest, conv_start, conv_done;
    logic [2:0] conv_channel, hch;
    logic [1:0] hv, cen, cdf;
    logic [1:0] cur_in = 2'b01;
    logic [5:0] crg;
    logic [15:0] raw0 = 16'h0000;
    int error_cnt = 0, check_count = 0;
    // gain, offset, raw, expected
    logic [63:0] rows [6] = '{64'h0000_0000_04d2_04d2, 64'h4000_0000_1000_0f00,
        64'hc000_fff8_1000_1102, 64'h0000_fe70_7ff0_7fff,
        64'h0000_0190_8010_8000, 64'h4000_0000_f000_f100};
    always #5 clk = ~clk;
    aac_adc_ctrl aac_adc_ctrl_i (.clk(clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .current_input(cur_in),
        .seq_clk_event(seq_ev), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_enable(cen), .conv_diff(cdf),
        .conv_range(crg), .conv_done(conv_done), .conv_data(conv_data),
        .host_wr_valid(hv), .host_wr_ch(hch), .host_wr_data(hd));
    aac_adc_model aac_adc_model_i (.clk(clk), .conv_start(conv_start),
        .conv_channel(conv_channel), .raw0(raw0), .conv_done(conv_done),
        .conv_data(conv_data));
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [1:0] devs);
        bus(1, AAC_CTRL_OFS, {30'h0, devs});
        do bus(0, AAC_STAT_OFS, 0); while (q[1:0] !== 2'b00);
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        bus(1, AAC_CFG_OFS, 32'h11);
        foreach (rows[i])
        begin
            raw0 <= rows[i][31:16];
            bus(1, AAC_CORR_OFS, {rows[i][47:32], rows[i][63:48]});
            run(2'b01);
            bus(0, AAC_DATA_OFS, 0);
            chk(q, {16'h0, rows[i][15:0]});
        end
        bus(0, AAC_CFG_OFS + 8'h04, 0);
        chk(q, 32'h10);
        bus(1, 8'h18, 32'h55);
        bus(0, 8'h18, 0);
        chk(q, 32'h0);
        bus(1, AAC_CFG_OFS, 32'h31);
        bus(1, AAC_CFG_OFS + 8'h04, 32'h20);
        bus(1, AAC_RANGE_OFS + 8'h08, 32'h2);
        bus(1, AAC_RANGE_OFS + 8'h28, 32'h3);
        run(2'b11);
        chk({22'h0, cen, cdf, crg}, 32'h15c);
        for (int c = 1; c < 3; c++)
        begin
            bus(0, AAC_DATA_OFS + 8'(4 * c), 0);
            chk(q, {16'h0, 16'hf000 + 16'(c * 256)});
        end
        for (int c = 0; c < 3; c++)
        begin
            bus(0, AAC_DATA_OFS + 8'(32 + 4 * c), 0);
            chk(q, (c < 2) ? {16'h0, 16'hf010 + 16'(c * 256)} : 0);
        end
        bus(1, AAC_CFG_OFS, 32'h81);
        bus(0, AAC_CFG_OFS, 0);
        chk(q, 32'h41);
        bus(0, AAC_MODE_OFS, 0);
        chk(q, 32'h0);
        bus(1, AAC_MODE_OFS, 32'h1);
        raw0 <= 16'h0100;
        seq_ev <= 1'b1;
        for (int n = 0; n < 200 && hv[0] !== 1'b1; n++) @(negedge clk);
        chk({hv, 11'h0, hch, hd[15:0]}, {2'b01, 30'h00f0});
        @(posedge clk);
        reset_n <= 1'b0;
        seq_ev <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        bus(0, AAC_MODE_OFS, 0);
        chk(q, 32'h0);
        bus(0, AAC_DATA_OFS, 0);
        chk(q, 32'h0);
        print_verdict();
    end
endmodule // tb_adc_acquisition_control
